// *** src/uvpf_pkg.sv ***
// Operation
// RQ1: A new frame is released to the USB side only once the FIFO fill level reaches the threshold.
// RQ2: The 11-bit threshold is split into low bits at 0x04 and bits 2 to 0 of 0x05.
// RQ3: Bit 7 of 0x05 makes the packetizer run when 1 and stop when 0.
// RQ4: Software leaves threshold, packet size and read period alone while running.
// RQ5: Packets carry exactly the programmed packet-size number of bytes, 0 to 1023. The code holds frames at size 0 and cuts a frame's last packet at eof.
// RQ6: The 10-bit packet size is split into low bits at 0x06 and bits 1 to 0 of 0x07.
// RQ7: Bits 7 to 2 of 0x07 hold the read-pulse period, 1 to 63.
// RQ8: The period is counted in clock cycles and a zero period acts as one. The code keeps pulses at least 3 cycles apart, so periods 0 to 2 give 3.
package uvpf_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] UVPF_OFS_THR_LO  = 8'h04;
    localparam logic [7:0] UVPF_OFS_THR_HI  = 8'h05;
    localparam logic [7:0] UVPF_OFS_LEN_LO  = 8'h06;
    localparam logic [7:0] UVPF_OFS_LEN_HI  = 8'h07;

    localparam int UVPF_THR_W      = 11;
    localparam int UVPF_LEN_W      = 10;
    localparam int UVPF_PER_W      = 6;
    localparam int UVPF_DATA_W     = 8;
    localparam int UVPF_LEVEL_W    = 12;
    localparam int UVPF_ACTIVE_BIT = 7;
    localparam int UVPF_BUSY_BIT   = 6;
    localparam int UVPF_THR_HI_MSB = 2;
    localparam int UVPF_LEN_HI_MSB = 1;
    localparam int UVPF_PER_LSB    = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [UVPF_THR_W-1:0] UVPF_RST_THR    = 11'h000;
    localparam logic [UVPF_LEN_W-1:0] UVPF_RST_LEN    = 10'h000;
    localparam logic [UVPF_PER_W-1:0] UVPF_RST_PER    = 6'h01;
    localparam logic                  UVPF_RST_ACTIVE = 1'h0;
    localparam logic [UVPF_PER_W-1:0] UVPF_PER_ONE    = 6'h01;
    localparam logic [UVPF_PER_W-1:0] UVPF_PER_SAT    = 6'h3f;

    // Buffer word: sof, last, eof, data
    localparam int UVPF_BUF_W = UVPF_DATA_W + 3;

    typedef enum logic [1:0] {
        UVPF_IDLE,
        UVPF_WAIT_FILL,
        UVPF_STREAM
    } uvpf_state_e;

endpackage : uvpf_pkg

// *** src/uvpf_stream_if.sv ***
`timescale 1ns/10ps
interface uvpf_stream_if #(parameter int W = 8) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input  ready);
    modport snk (input  valid, input  data, output ready);
endinterface : uvpf_stream_if

// *** src/uvpf_pair_buf.sv ***
`timescale 1ns/10ps
module uvpf_pair_buf
    import uvpf_pkg::*;
#(
    parameter int W = UVPF_BUF_W
) (
    input  wire logic    i_clock,
    input  wire logic    i_rstn,
    uvpf_stream_if.snk   s_in,
    uvpf_stream_if.src   s_out
);

    logic [W-1:0] head_r;
    logic [W-1:0] tail_r;
    logic [1:0]   cnt_r;
    logic         valid_r;
    logic         full_r;

    wire          push     = s_in.valid && !full_r;
    wire          pop      = valid_r && s_out.ready;
    wire [1:0]    cnt_nxt  = cnt_r + {1'b0, push} - {1'b0, pop};
    wire          load_in  = (cnt_r == 2'd0 && push) || (cnt_r == 2'd1 && push && pop);
    wire          shift    = (cnt_r == 2'd2) && pop;
    wire          load_tl  = (cnt_r == 2'd1) && push && !pop;
    wire [W-1:0]  head_nxt = load_in ? s_in.data : (shift ? tail_r : head_r);
    wire [W-1:0]  tail_nxt = load_tl ? s_in.data : tail_r;

    // Flags are registered so the top's outputs come from flip-flops
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            cnt_r   <= 2'd0;
            valid_r <= 1'b0;
            full_r  <= 1'b0;
            head_r  <= '0;
            tail_r  <= '0;
        end
        else
        begin
            cnt_r   <= cnt_nxt;
            valid_r <= (cnt_nxt != 2'd0);
            full_r  <= (cnt_nxt == 2'd2);
            head_r  <= head_nxt;
            tail_r  <= tail_nxt;
        end
    end

    assign s_in.ready  = !full_r;
    assign s_out.valid = valid_r;
    assign s_out.data  = head_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_buf_no_drop: assert property (@(posedge i_clock) disable iff (!i_rstn)
        s_in.valid |-> s_in.ready)
        else $error("word offered to a full buffer");

    chk_buf_out_hold: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (s_out.valid && !s_out.ready) |=> (s_out.valid && $stable(s_out.data)))
        else $error("stalled output word changed or vanished");

endmodule : uvpf_pair_buf

// *** src/uvpf_top.sv ***
`timescale 1ns/10ps
module uvpf_top
    import uvpf_pkg::*;
#(
    parameter int LEVEL_W = UVPF_LEVEL_W
) (
    input  wire logic                   i_clock,
    input  wire logic                   i_rstn,
    input  wire logic                   i_reg_wr,
    input  wire logic                   i_reg_rd,
    input  wire logic [7:0]             i_reg_addr,
    input  wire logic [7:0]             i_reg_wdata,
    output logic      [7:0]             o_reg_rdata,
    output logic                        o_reg_rvalid,
    input  wire logic [LEVEL_W-1:0]     i_fifo_level,
    input  wire logic                   i_fifo_empty,
    output logic                        o_fifo_rd,
    input  wire logic [UVPF_DATA_W-1:0] i_fifo_data,
    input  wire logic                   i_fifo_eof,
    output logic                        o_usb_valid,
    output logic [UVPF_DATA_W-1:0]      o_usb_data,
    output logic                        o_usb_sof,
    output logic                        o_usb_last,
    output logic                        o_usb_eof,
    input  wire logic                   i_usb_ready
);

    // ------------------------------------------------------------
    // Settings
    // ------------------------------------------------------------
    logic [UVPF_THR_W-1:0] thr_r;
    logic [UVPF_LEN_W-1:0] len_r;
    logic [UVPF_PER_W-1:0] per_r;
    logic                  active_r;
    logic [7:0]            rdata_r;
    logic                  rvalid_r;

    wire hit_thr_lo = i_reg_addr == UVPF_OFS_THR_LO;
    wire hit_thr_hi = i_reg_addr == UVPF_OFS_THR_HI;
    wire hit_len_lo = i_reg_addr == UVPF_OFS_LEN_LO;
    wire hit_len_hi = i_reg_addr == UVPF_OFS_LEN_HI;
    wire wr_thr_lo  = i_reg_wr && hit_thr_lo;
    wire wr_thr_hi  = i_reg_wr && hit_thr_hi;
    wire wr_len_lo  = i_reg_wr && hit_len_lo;
    wire wr_len_hi  = i_reg_wr && hit_len_hi;

    // RQ2: threshold halves
    wire [UVPF_THR_W-1:0] thr_nxt = {
        wr_thr_hi ? i_reg_wdata[UVPF_THR_HI_MSB:0] : thr_r[UVPF_THR_W-1:8],
        wr_thr_lo ? i_reg_wdata : thr_r[7:0]};
    // RQ6: packet size halves
    wire [UVPF_LEN_W-1:0] len_nxt = {
        wr_len_hi ? i_reg_wdata[UVPF_LEN_HI_MSB:0] : len_r[UVPF_LEN_W-1:8],
        wr_len_lo ? i_reg_wdata : len_r[7:0]};
    // RQ7: read period field
    wire [UVPF_PER_W-1:0] per_nxt = wr_len_hi ? i_reg_wdata[7:UVPF_PER_LSB] : per_r;
    // RQ3: running flag
    wire active_nxt = wr_thr_hi ? i_reg_wdata[UVPF_ACTIVE_BIT] : active_r;

    // Writes are taken at any time; keeping settings still while running is software's job
    // RQ4: settings only change on a write
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            thr_r    <= UVPF_RST_THR;
            len_r    <= UVPF_RST_LEN;
            per_r    <= UVPF_RST_PER;
            active_r <= UVPF_RST_ACTIVE;
        end
        else
        begin
            thr_r    <= thr_nxt;
            len_r    <= len_nxt;
            per_r    <= per_nxt;
            active_r <= active_nxt;
        end
    end

    // ------------------------------------------------------------
    // Pacing state
    // ------------------------------------------------------------
    uvpf_state_e           state_r;
    uvpf_state_e           state_nxt;
    logic [UVPF_PER_W-1:0] per_cnt_r;
    logic [UVPF_LEN_W-1:0] byte_cnt_r;
    logic                  first_r;
    logic                  rd_r;
    logic                  rd_dly_r;
    logic                  meta_sof_r;
    logic                  meta_last_r;

    uvpf_stream_if #(.W(UVPF_BUF_W)) fill_if ();
    uvpf_stream_if #(.W(UVPF_BUF_W)) drain_if ();

    wire busy = state_r == UVPF_STREAM;

    // Register readback, busy bit shows a frame in flight
    wire [7:0] rd_mux =
        hit_thr_lo ? thr_r[7:0] :
        hit_thr_hi ? {active_r, busy, 3'h0, thr_r[UVPF_THR_W-1:8]} :
        hit_len_lo ? len_r[7:0] :
        hit_len_hi ? {per_r, len_r[UVPF_LEN_W-1:8]} : 8'h00;

    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rdata_r  <= i_reg_rd ? rd_mux : rdata_r;
            rvalid_r <= i_reg_rd;
        end
    end

    // RQ8: zero period acts as one
    wire [UVPF_PER_W-1:0] per_eff = (per_r == 6'h00) ? UVPF_PER_ONE : per_r;
    // RQ1: fill level against threshold
    wire fill_ok = i_fifo_level >= LEVEL_W'(thr_r);
    // RQ8: cycles since the last pulse
    wire tick    = per_cnt_r >= (per_eff - UVPF_PER_ONE);
    // One read in flight at a time keeps the two-entry buffer from overflowing
    wire rd_go   = busy && active_r && fill_if.ready && !rd_r && !rd_dly_r
                   && !i_fifo_empty && tick;
    // RQ5: last byte of a packet
    wire last_go = byte_cnt_r == (len_r - 10'h001);
    wire eof_in  = rd_dly_r && i_fifo_eof;

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            UVPF_IDLE:
            begin
                if (active_r)
                    state_nxt = UVPF_WAIT_FILL;
            end
            UVPF_WAIT_FILL:
            begin
                // RQ1: hold the frame until the fill level is reached
                if (!active_r)
                    state_nxt = UVPF_IDLE;
                else if (fill_ok && len_r != 10'h000)
                    state_nxt = UVPF_STREAM;
            end
            UVPF_STREAM:
            begin
                // RQ3: clearing the flag stops at once
                if (!active_r)
                    state_nxt = UVPF_IDLE;
                else if (eof_in)
                    state_nxt = UVPF_WAIT_FILL;
            end
            // The fourth code of the state word is unused; fall back to idle
            default:
            begin
                state_nxt = UVPF_IDLE;
            end
        endcase
    end

    wire enter = (state_r == UVPF_WAIT_FILL) && (state_nxt == UVPF_STREAM);
    // RQ7: restart the period on each pulse, saturate while not streaming
    wire [UVPF_PER_W-1:0] per_cnt_nxt =
        !busy ? UVPF_PER_SAT :
        rd_go ? 6'h00 :
        tick  ? per_cnt_r : per_cnt_r + 6'h01;
    // RQ5: bytes counted per packet
    wire [UVPF_LEN_W-1:0] byte_cnt_nxt =
        enter ? 10'h000 :
        rd_go ? (last_go ? 10'h000 : byte_cnt_r + 10'h001) : byte_cnt_r;

    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            state_r    <= UVPF_IDLE;
            per_cnt_r  <= UVPF_PER_SAT;
            byte_cnt_r <= 10'h000;
            first_r    <= 1'b0;
            rd_r       <= 1'b0;
            rd_dly_r   <= 1'b0;
        end
        else
        begin
            state_r    <= state_nxt;
            per_cnt_r  <= per_cnt_nxt;
            byte_cnt_r <= byte_cnt_nxt;
            first_r    <= enter ? 1'b1 : (rd_go ? 1'b0 : first_r);
            rd_r       <= rd_go;
            rd_dly_r   <= rd_r;
        end
    end

    // Tags of a byte are held until the next read, which cannot come earlier
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            meta_sof_r  <= 1'b0;
            meta_last_r <= 1'b0;
        end
        else if (rd_go)
        begin
            meta_sof_r  <= first_r;
            meta_last_r <= last_go;
        end
    end

    // ------------------------------------------------------------
    // Output buffer
    // ------------------------------------------------------------
    assign fill_if.valid = rd_dly_r;
    assign fill_if.data  = {meta_sof_r, meta_last_r | i_fifo_eof, i_fifo_eof, i_fifo_data};
    assign drain_if.ready = i_usb_ready;

    uvpf_pair_buf #(
        .W (UVPF_BUF_W)
    ) u_buf (
        .i_clock (i_clock),
        .i_rstn  (i_rstn),
        .s_in    (fill_if),
        .s_out   (drain_if)
    );

    assign o_reg_rdata  = rdata_r;
    assign o_reg_rvalid = rvalid_r;
    assign o_fifo_rd    = rd_r;
    assign o_usb_valid  = drain_if.valid;
    assign o_usb_data   = drain_if.data[UVPF_DATA_W-1:0];
    assign o_usb_eof    = drain_if.data[UVPF_DATA_W];
    assign o_usb_last   = drain_if.data[UVPF_DATA_W+1];
    assign o_usb_sof    = drain_if.data[UVPF_DATA_W+2];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [UVPF_LEN_W-1:0] out_cnt_r;
    logic [6:0]            gap_r;
    wire                   usb_take = o_usb_valid && i_usb_ready;
    // A start byte restarts the count, so a frame cut by a stop leaves nothing stale
    wire [UVPF_LEN_W-1:0]  out_cnt_nxt =
        !usb_take  ? out_cnt_r :
        o_usb_last ? 10'h000 :
        o_usb_sof  ? 10'h001 : out_cnt_r + 10'h001;

    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            out_cnt_r <= 10'h000;
            gap_r     <= 7'h7f;
        end
        else
        begin
            out_cnt_r <= out_cnt_nxt;
            gap_r     <= rd_go ? 7'h01 : ((gap_r == 7'h7f) ? gap_r : gap_r + 7'h01);
        end
    end

    sequence s_wr_hi;
        i_reg_wr && i_reg_addr == UVPF_OFS_THR_HI;
    endsequence

    sequence s_wr_len_hi;
        i_reg_wr && i_reg_addr == UVPF_OFS_LEN_HI;
    endsequence

    chk_frame_gate_fill: assert property (@(posedge i_clock) disable iff (!i_rstn) // RQ1
        (state_r == UVPF_WAIT_FILL && !fill_ok) |=> (state_r != UVPF_STREAM))
        else $error("frame released below the fill threshold");

    chk_thr_high_bits: assert property (@(posedge i_clock) disable iff (!i_rstn) // RQ2
        s_wr_hi |=> (thr_r[UVPF_THR_W-1:8] == $past(i_reg_wdata[2:0])))
        else $error("threshold high bits not taken");

    chk_active_write: assert property (@(posedge i_clock) disable iff (!i_rstn) // RQ3
        s_wr_hi ##1 (!active_r) |=> (state_r == UVPF_IDLE) ##1 (!o_fifo_rd))
        else $error("packetizer kept running after stop");

    chk_read_when_run: assert property (@(posedge i_clock) disable iff (!i_rstn) // RQ3
        $rose(o_fifo_rd) |-> $past(busy && active_r))
        else $error("read pulse while not running");

    chk_packet_length: assert property (@(posedge i_clock) disable iff (!i_rstn) // RQ5
        (usb_take && o_usb_last && !o_usb_eof) |-> (out_cnt_r == len_r - 10'h001))
        else $error("packet length differs from setting");

    chk_len_high_bits: assert property (@(posedge i_clock) disable iff (!i_rstn) // RQ6
        s_wr_len_hi |=> (len_r[UVPF_LEN_W-1:8] == $past(i_reg_wdata[1:0])))
        else $error("packet size high bits not taken");

    chk_period_field: assert property (@(posedge i_clock) disable iff (!i_rstn) // RQ7
        s_wr_len_hi |=> (per_r == $past(i_reg_wdata[7:2])))
        else $error("read period not taken");

    chk_pulse_spacing: assert property (@(posedge i_clock) disable iff (!i_rstn) // RQ8
        (rd_go && !first_r) |-> (gap_r >= {1'b0, per_eff}))
        else $error("read pulses closer than the period");

    // RQ8: read in flight blocks
    chk_pulse_in_flight: assert property (@(posedge i_clock) disable iff (!i_rstn) // RQ8
        o_fifo_rd |=> (!o_fifo_rd ##1 !o_fifo_rd))
        else $error("read pulse while a byte is in flight");

    // RQ5: zero size holds
    chk_size_zero_hold: assert property (@(posedge i_clock) disable iff (!i_rstn) // RQ5
        (state_r == UVPF_WAIT_FILL && len_r == 10'h000) |=> (state_r != UVPF_STREAM))
        else $error("frame released with zero packet size");

endmodule : uvpf_top

// *** testbench/uvpf_usb_model.sv ***
`timescale 1ns/10ps
module uvpf_usb_model
    import uvpf_pkg::*;
(
    input  wire logic                   i_clock,
    input  wire logic                   i_clear,
    input  wire logic                   i_stall,
    input  wire logic                   i_valid,
    input  wire logic [UVPF_DATA_W-1:0] i_data,
    input  wire logic                   i_sof,
    input  wire logic                   i_last,
    input  wire logic                   i_eof,
    output logic                        o_ready,
    output logic [15:0]                 o_bytes,
    output logic [15:0]                 o_sofs,
    output logic [15:0]                 o_lasts,
    output logic [15:0]                 o_eofs,
    output logic [15:0]                 o_bad
);
    // Ready drops while stalled, so the pair buffer must hold every word
    assign o_ready = ~i_stall;

    always @(posedge i_clock)
    begin
        if (i_clear)
        begin
            o_bytes <= 16'h0000;
            o_sofs  <= 16'h0000;
            o_lasts <= 16'h0000;
            o_eofs  <= 16'h0000;
            o_bad   <= 16'h0000;
        end
        else if (i_valid === 1'b1 && o_ready)
        begin
            o_bytes <= o_bytes + 16'h0001;
            o_sofs  <= o_sofs + 16'(i_sof);
            o_lasts <= o_lasts + 16'(i_last);
            o_eofs  <= o_eofs + 16'(i_eof);
            // Bytes come in source order, none lost; start flag only on the first
            if (i_data !== o_bytes[7:0] || i_sof !== (o_bytes == 16'h0000))
                o_bad <= o_bad + 16'h0001;
        end
    end
endmodule : uvpf_usb_model

// *** testbench/uvpf_top_tb_top.sv ***
`timescale 1ns/10ps
module uvpf_top_tb_top
    import uvpf_pkg::*;
;
    logic        clock = 1'b0;
    logic        rstn  = 1'b0;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic [7:0]  addr  = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic [11:0] level = 12'h000;
    logic        empty = 1'b1;
    logic [7:0]  fdata = 8'h00;
    logic        feof  = 1'b0;
    logic        clear = 1'b1;
    logic        stall = 1'b0;
    logic [7:0]  rdata, udata;
    logic        rvalid, frd, uvalid, usof, ulast, ueof, uready;
    logic [15:0] nbytes, nsof, nlast, neof, nbad;
    int          err_total = 0;
    int          n_compared = 0;
    int          cyc = 0, last_rd = 0, gap = 0, rd_cnt = 0, idx = 0, flen = 0;
    // Rows: write flag, offset, write data, expected read
    logic [24:0] rows [10] = '{
        {1'b0, 8'h04, 8'h00, 8'h00}, {1'b0, 8'h05, 8'h00, 8'h00},
        {1'b0, 8'h06, 8'h00, 8'h00}, {1'b0, 8'h07, 8'h00, 8'h04},
        {1'b1, 8'h04, 8'ha5, 8'ha5}, {1'b1, 8'h05, 8'h3f, 8'h07},
        {1'b1, 8'h06, 8'h5a, 8'h5a}, {1'b1, 8'h07, 8'hff, 8'hff},
        {1'b1, 8'h08, 8'h55, 8'h00}, {1'b1, 8'h05, 8'h00, 8'h00}};

    always #2 clock = ~clock;

    uvpf_top uvpf_top_inst (
        .i_clock(clock), .i_rstn(rstn), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_fifo_level(level), .i_fifo_empty(empty), .o_fifo_rd(frd), .i_fifo_data(fdata),
        .i_fifo_eof(feof), .o_usb_valid(uvalid), .o_usb_data(udata), .o_usb_sof(usof),
        .o_usb_last(ulast), .o_usb_eof(ueof), .i_usb_ready(uready));

    uvpf_usb_model uvpf_usb_model_inst (
        .i_clock(clock), .i_clear(clear), .i_stall(stall), .i_valid(uvalid),
        .i_data(udata), .i_sof(usof), .i_last(ulast), .i_eof(ueof), .o_ready(uready),
        .o_bytes(nbytes), .o_sofs(nsof), .o_lasts(nlast), .o_eofs(neof), .o_bad(nbad));

    // ------------------------------------------------------------
    // Video source: byte answers its read pulse one cycle later
    // ------------------------------------------------------------
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (clear)
        begin
            idx    <= 0;
            rd_cnt <= 0;
            empty  <= #1 (flen == 0);
        end
        else if (frd === 1'b1)
        begin
            gap     <= cyc - last_rd;
            last_rd <= cyc;
            rd_cnt  <= rd_cnt + 1;
            idx     <= idx + 1;
            fdata   <= #1 idx[7:0];
            feof    <= #1 (idx == flen - 1);
            empty   <= #1 (idx + 1 >= flen);
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_cnt

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        step(1);
        wr = 1'b1;
        addr = a;
        wdata = d;
        step(1);
        wr = 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        step(1);
        rd = 1'b1;
        addr = a;
        step(1);
        rd = 1'b0;
        chk_reg({7'h00, rvalid}, 8'h01);
        chk_reg(rdata, e);
    endtask : reg_rd

    task automatic cfg(input logic [10:0] thr, input logic [9:0] len, input logic [5:0] per);
        reg_wr(UVPF_OFS_THR_HI, 8'h00);
        reg_wr(UVPF_OFS_THR_LO, thr[7:0]);
        reg_wr(UVPF_OFS_LEN_LO, len[7:0]);
        reg_wr(UVPF_OFS_LEN_HI, {per, len[9:8]});
        reg_wr(UVPF_OFS_THR_HI, {5'h10, thr[10:8]});
    endtask : cfg

    task automatic new_frame(input int n);
        flen = n;
        clear = 1'b1;
        step(1);
        clear = 1'b0;
    endtask : new_frame

    task automatic wait_eof;
        int k;
        k = 0;
        while (neof === 16'h0000 && k < 2000)
        begin
            step(1);
            k++;
        end
        if (k >= 2000)
            err_total++;
        step(10);
    endtask : wait_eof

    // Level one short of threshold holds the frame back, then releases it
    task automatic run_case(input logic [10:0] thr, input logic [9:0] len,
                            input logic [5:0] per, input int n,
                            input logic [15:0] lasts, input logic [15:0] spc);
        level = {1'b0, thr} - 12'h001;
        cfg(thr, len, per);
        new_frame(n);
        step(40);
        chk_cnt(16'(rd_cnt), 16'h0000);
        level = {1'b0, thr};
        wait_eof;
        chk_cnt(nbytes, 16'(n));
        chk_cnt(nsof, 16'h0001);
        chk_cnt(nlast, lasts);
        chk_cnt(nbad, 16'h0000);
        chk_cnt(16'(gap), spc);
    endtask : run_case

    task automatic wrap_up;
        $display("compared=%0d mismatches=%0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    initial
    begin
        #40000;
        err_total++;
        wrap_up();
    end

    initial
    begin
        int k;
        step(16);
        chk_reg({5'h00, frd, uvalid, rvalid}, 8'h00);
        rstn = 1'b1;
        foreach (rows[i])
        begin
            if (rows[i][24])
                reg_wr(rows[i][23:16], rows[i][15:8]);
            reg_rd(rows[i][23:16], rows[i][7:0]);
        end
        run_case(11'h105, 10'h003, 6'h05, 7, 16'h0003, 16'h0005);
        run_case(11'h7ff, 10'h3ff, 6'h00, 5, 16'h0001, 16'h0003);
        run_case(11'h001, 10'h002, 6'h3f, 3, 16'h0002, 16'h003f);
        // Stalled receiver: frame in flight shows busy, and no byte is lost
        stall = 1'b1;
        cfg(11'h000, 10'h002, 6'h01);
        new_frame(6);
        step(40);
        reg_rd(UVPF_OFS_THR_HI, 8'hc0);
        stall = 1'b0;
        wait_eof;
        chk_cnt(nbytes, 16'h0006);
        chk_cnt(nlast, 16'h0003);
        chk_cnt(nbad, 16'h0000);
        // Clearing the running flag mid-frame stops further reads
        cfg(11'h000, 10'h004, 6'h0a);
        new_frame(20);
        step(25);
        reg_wr(UVPF_OFS_THR_HI, 8'h00);
        step(2);
        k = rd_cnt;
        step(60);
        chk_cnt(16'(rd_cnt), 16'(k));
        chk_cnt(16'(k > 0 && k < 20), 16'h0001);
        // Reset after the stop: outputs idle, 0x05 and 0x07 read back their reset values
        rstn = 1'b0;
        step(2);
        chk_reg({5'h00, frd, uvalid, rvalid}, 8'h00);
        rstn = 1'b1;
        reg_rd(UVPF_OFS_THR_HI, 8'h00);
        reg_rd(UVPF_OFS_LEN_HI, 8'h04);
        wrap_up();
    end
endmodule : uvpf_top_tb_top
